// ===== verilog/sysref_lmfc_alignment_control.sv
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sysref_lmfc_alignment_control #(
  parameter int FK = lmfc_align_pkg::FK_DEFAULT
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic sysref,
  input wire logic [1:0] subclass,
  input wire logic cgs_request,
  input wire logic cgs_done,
  output logic in_cgs,
  output logic in_ilas,
  output logic lmfc_tick,
  output logic [7:0] lmfc_count
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic [2:0] sref_sync;
    logic sysref_seen;
    lmfc_align_pkg::link_state_t st;
    logic in_cgs;
    logic in_ilas;
    logic tick;
    logic [7:0] count;
  } state_t;
  state_t s_q, s_d;
  if (FK < 8 || FK > 1024 || (FK % 4) != 0) begin : g_bad_fk
    $error("FK out of range");
  end
  logic sref_rise;
  logic cnt_tick;
  logic [7:0] cnt_val;
  logic bypass;
  // Only the second and third stages feed logic; first is metastability guard
  assign sref_rise = s_q.sref_sync[1] & ~s_q.sref_sync[2];
  lmfc_counter #(.FK(FK)) u_cnt (
    .clk(clk),
    .arst_n(arst_n),
    .load(sref_rise),
    .preset(s_q.ctrl[lmfc_align_pkg::PRESET_MSB:lmfc_align_pkg::PRESET_LSB]),
    .count(cnt_val),
    .tick(cnt_tick)
  );
  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h00000000;
    s_d.sref_sync = {s_q.sref_sync[1:0], sysref};
    bypass = s_q.ctrl[lmfc_align_pkg::BYPASS_BIT] &&
             (subclass == lmfc_align_pkg::SUBCLASS_ONE);
    if (wr && addr == lmfc_align_pkg::CTRL_OFFSET) begin
      s_d.ctrl = wdata & lmfc_align_pkg::CTRL_WRITABLE;
    end
    // Hardware clear wins over a same-cycle software set, arm must follow edge
    if (sref_rise) begin
      s_d.ctrl[lmfc_align_pkg::SINGLEDET_BIT] = 1'b0;
      s_d.sysref_seen = 1'b1;
    end
    if (rd) begin
      case (addr)
        lmfc_align_pkg::CTRL_OFFSET: s_d.rdata = s_q.ctrl;
        lmfc_align_pkg::STATUS_OFFSET: begin
          s_d.rdata = {20'h00000, s_q.count, s_q.sysref_seen, 1'b0, s_q.st};
        end
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    case (s_q.st)
      lmfc_align_pkg::ST_IDLE: begin
        if (cgs_request) begin
          s_d.st = lmfc_align_pkg::ST_CGS;
        end
      end
      lmfc_align_pkg::ST_CGS: begin
        // Exit only on tick; without bypass, armed flag must have cleared
        if (cgs_done && cnt_tick &&
            (bypass || (s_q.sysref_seen &&
             !s_q.ctrl[lmfc_align_pkg::SINGLEDET_BIT]))) begin
          s_d.st = lmfc_align_pkg::ST_ILAS;
        end
      end
      lmfc_align_pkg::ST_ILAS: begin
        if (cgs_request) begin
          s_d.st = lmfc_align_pkg::ST_CGS;
        end
      end
      default: s_d.st = lmfc_align_pkg::ST_IDLE;
    endcase
    s_d.in_cgs = (s_d.st == lmfc_align_pkg::ST_CGS);
    s_d.in_ilas = (s_d.st == lmfc_align_pkg::ST_ILAS);
    s_d.tick = cnt_tick;
    s_d.count = cnt_val;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.ctrl <= lmfc_align_pkg::CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  assign rdata = s_q.rdata;
  assign in_cgs = s_q.in_cgs;
  assign in_ilas = s_q.in_ilas;
  assign lmfc_tick = s_q.tick;
  assign lmfc_count = s_q.count;
endmodule
`default_nettype wire

// ===== verilog/lmfc_align_pkg.sv
package lmfc_align_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h54;
  localparam logic [7:0] STATUS_OFFSET = 8'h58;
  localparam int SINGLEDET_BIT = 2;
  localparam int PRESET_LSB = 12;
  localparam int PRESET_MSB = 19;
  localparam int BYPASS_BIT = 20;
  localparam logic [31:0] CTRL_WRITABLE = 32'h001ff07c;
  localparam logic [31:0] CTRL_RESET = 32'h00000004;
  localparam logic [1:0] SUBCLASS_ONE = 2'h1;
  localparam int FK_DEFAULT = 128;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CGS = 2'b01,
    ST_ILAS = 2'b10
  } link_state_t;
endpackage

// ===== verilog/lmfc_counter.sv
`timescale 1ns/1ps
`default_nettype none
module lmfc_counter #(
  parameter int FK = lmfc_align_pkg::FK_DEFAULT
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [7:0] preset,
  output logic [7:0] count,
  output logic tick
);
  localparam logic [7:0] MAX_COUNT = 8'((FK / 4) - 1);
  // Eight-bit counter limits the multiframe to 256 link clocks
  if (FK < 8 || FK > 1024 || (FK % 4) != 0) begin : g_bad_fk
    $error("FK out of range");
  end
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } cnt_state_t;
  cnt_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (load) begin
      // Out-of-range preset falls back to zero
      s_d.cnt = (preset > MAX_COUNT) ? 8'h00 : preset;
    end else if (s_q.cnt == MAX_COUNT) begin
      s_d.cnt = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign count = s_q.cnt;
  assign tick = s_q.tick;
endmodule
`default_nettype wire

// ===== verification/converter_model.sv
`timescale 1ns/1ps
`default_nettype none
module converter_model (
  input wire logic clk,
  input wire logic fire,
  output logic sysref = 1'b0
);
  // Launched off the clock so both ends see the same edge
  always @(posedge clk) sysref <= fire;
endmodule
`default_nettype wire

// ===== verification/lmfc_align_props.sv
`timescale 1ns/1ps
`default_nettype none
module lmfc_align_props #(
  parameter int FK = 128
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sysref,
  input wire logic cgs_done,
  input wire logic in_cgs,
  input wire logic in_ilas,
  input wire logic lmfc_tick,
  input wire logic [7:0] lmfc_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_count_range: assert property (lmfc_count < FK / 4) else $error("range");
  a_count_step: assert property (!sysref [*6] |=>
    lmfc_count == 8'(($past(lmfc_count) + 1) % (FK / 4))) else $error("step");
  a_tick_single: assert property (lmfc_tick |=> !lmfc_tick) else $error("tick");
  a_tick_wrap: assert property (!sysref [*8] ##0 lmfc_tick |->
    lmfc_count < 2) else $error("wrap");
  a_ilas_tick: assert property ($rose(in_ilas) |-> ##[0:1] lmfc_tick) else $error("ilas");
  a_ilas_cgs: assert property ($rose(in_ilas) |-> $past(in_cgs)) else $error("order");
  a_done_needed: assert property (!cgs_done [*4] |=> !$rose(in_ilas)) else $error("done");
  a_state_excl: assert property (!(in_cgs && in_ilas)) else $error("state");
  c_ilas: cover property ($rose(in_ilas));
  c_sysref: cover property ($rose(sysref));
  c_tick: cover property (lmfc_tick);
endmodule
bind sysref_lmfc_alignment_control lmfc_align_props #(.FK(FK)) i_props (.clk(clk),
  .arst_n(arst_n), .sysref(sysref), .cgs_done(cgs_done), .in_cgs(in_cgs),
  .in_ilas(in_ilas), .lmfc_tick(lmfc_tick), .lmfc_count(lmfc_count));
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] C = lmfc_align_pkg::CTRL_OFFSET;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, fire = 0, cgs_done = 0, sysref;
  logic [7:0] addr = 0, lmfc_count, v;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] subclass = 0;
  logic in_cgs, in_ilas, lmfc_tick;
  logic cgs_request = 0;
  int failures = 0, checks_done = 0, seed = 32'hfa91901b;
  int n;
  always #2 clk = ~clk;
  converter_model i_conv (.clk(clk), .fire(fire), .sysref(sysref));
  sysref_lmfc_alignment_control #(.FK(32)) i_dut (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sysref(sysref), .subclass(subclass),
    .cgs_request(cgs_request), .cgs_done(cgs_done), .in_cgs(in_cgs), .in_ilas(in_ilas),
    .lmfc_tick(lmfc_tick), .lmfc_count(lmfc_count));
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1;
    acc(0, 8'h00, 0);
    chk(rdata, 0);
    acc(0, C, 0);
    chk(rdata, lmfc_align_pkg::CTRL_RESET);
    cgs_done <= 1;
    cgs_request <= 1;
    // Debug-only fast link-up, deterministic latency not needed here
    acc(1, C, 32'h00100004);
    cgs_request <= 0;
    repeat (40) @(posedge clk);
    chk(in_ilas, 0);
    chk(in_cgs, 1);
    subclass <= lmfc_align_pkg::SUBCLASS_ONE;
    repeat (40) @(posedge clk);
    chk(in_ilas, 1);
    n = 0;
    repeat (16) begin
      @(posedge clk);
      #1;
      n += lmfc_tick;
    end
    chk(n, 2);
    $display("test bypass done");
    for (int i = 0; i < 4; i++) begin
      v = i == 0 ? 0 : i == 1 ? 8'h08 : i == 2 ? 8'hff : 8'($unsigned($random(seed)) % 8);
      acc(1, C, {12'h0, v, 12'h004});
      fire <= 1;
      @(posedge clk);
      fire <= 0;
      repeat (9) @(posedge clk);
      #1;
      chk(lmfc_count, ((v < 8 ? v : 0) + 5) % 8);
      acc(0, C, 0);
      chk(rdata, {12'h0, v, 12'h0});
      $display("test preset done");
    end
    summarize();
  end
endmodule
`default_nettype wire
